//--- core/bbps_core.sv
`include "bbps_defs.svh"
module bbps_core import bbps_pkg::*; #(
  parameter int START_CYC = `BBPS_T_START_NS / `BBPS_CLK_NS,
  parameter int PGON_CYC = `BBPS_T_PGON_NS / `BBPS_CLK_NS,
  parameter int DVSTO_CYC = `BBPS_T_DVSTO_MS * (`BBPS_NS_PER_MS / `BBPS_CLK_NS)
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic en_pin,
  input wire logic addr_sel,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic forward_mode,
  input wire logic bus_is_5v,
  input wire bbps_cmp_t cmp_raw,
  input wire logic [4:0][10:0] adc_result,
  output logic sda_out,
  output logic sda_oe,
  output bbps_gate_t gates,
  output logic typec_path_gate,
  output logic typea_path_gate,
  output logic ss_charge_en,
  output logic discharge_on,
  output logic power_good_out,
  output logic alert_n,
  output logic zcd_en,
  output logic [15:0] dvs_level
);
  localparam int PGOFF_CYC = `BBPS_T_PGOFF_NS / `BBPS_CLK_NS;
  localparam int SLEW_CYC = `BBPS_T_SLEW_NS / `BBPS_CLK_NS;
  localparam int OSC_CYC = `BBPS_CLK_KHZ / `BBPS_F_SW_KHZ;
  localparam bbps_gate_t GATE_ACT = '{1'b1, 1'b0, 1'b0, 1'b1};
  localparam bbps_gate_t GATE_CMP = '{1'b0, 1'b1, 1'b1, 1'b0};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  function automatic logic [7:0] rst_val(input int i);
    case (6'(i))
      `BBPS_R_MODE: rst_val = `BBPS_RST_MODE;
      `BBPS_R_CONV: rst_val = `BBPS_RST_CONV;
      `BBPS_R_CONVX: rst_val = `BBPS_RST_CONVX;
      `BBPS_R_PATH: rst_val = `BBPS_RST_PATH;
      default: rst_val = `BBPS_RST_ZERO;
    endcase
  endfunction

  function automatic logic is_rw(input logic [5:0] a);
    case (a)
      `BBPS_R_VTGT_L, `BBPS_R_VTGT_H, `BBPS_R_CC_L, `BBPS_R_CC_H, `BBPS_R_PEAK,
      `BBPS_R_MODE, `BBPS_R_ENDIS, `BBPS_R_CONV, `BBPS_R_RATIO, `BBPS_R_EVTM,
      `BBPS_R_PATH, `BBPS_R_CONVX, `BBPS_R_TOM: is_rw = 1'b1;
      default: is_rw = 1'b0;
    endcase
  endfunction

  // Comparator inputs are asynchronous to this clock.
  logic [$bits(bbps_cmp_t)-1:0] cmp_s1, cmp_s2;
  bbps_cmp_t cmp;
  assign cmp = cmp_s2;
  for (genvar i = 0; i < $bits(bbps_cmp_t); i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        cmp_s1[i] <= 1'b0;
        cmp_s2[i] <= 1'b0;
      end else begin
        cmp_s1[i] <= cmp_raw[i];
        cmp_s2[i] <= cmp_s1[i];
      end
    end
  end

  // Lockout or a low enable pin holds the registers, the I2C target, the event flags and the path gates in reset.
  wire dig_rst = !cmp.undervoltage_lockout_ok || !en_pin;

  bbps_regbus_t bus;
  logic [7:0] rd_data;
  logic addr_lsb, addr_cap;
  bbps_i2c_target u_i2c (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .srst(dig_rst),
    .dev_addr({`BBPS_I2C_ADDR_HI, addr_lsb}),
    .scl(scl),
    .sda_in(sda_in),
    .rd_data(rd_data),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .bus(bus)
  );

  // The strap is caught once, in the first cycle after reset release.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addr_lsb <= 1'b0;
      addr_cap <= 1'b0;
    end else if (!addr_cap) begin
      addr_lsb <= addr_sel;
      addr_cap <= 1'b1;
    end
  end

  logic [7:0] regs [0:63];
  wire wr_hit = bus.wr && bus.ptr[7:6] == 2'b00;
  for (genvar i = 0; i < 64; i++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) regs[i] <= rst_val(i);
      else if (dig_rst) regs[i] <= rst_val(i);
      else if (wr_hit && bus.ptr[5:0] == 6'(i) && is_rw(6'(i))) regs[i] <= bus.wdata;
    end
  end

  wire [7:0] r_mode = regs[`BBPS_R_MODE];
  wire [7:0] r_endis = regs[`BBPS_R_ENDIS];
  wire [7:0] r_path = regs[`BBPS_R_PATH];
  wire sw_en = r_endis[`BBPS_B_SWEN];
  wire forced_continuous_mode = r_mode[`BBPS_B_FORCED_CONTINUOUS_MODE];
  wire [3:0] slew = r_mode[6:3];
  wire [15:0] vt = {regs[`BBPS_R_VTGT_H], regs[`BBPS_R_VTGT_L]};
  // The coarse ratio doubles the weight of each target step.
  wire [15:0] tgt = regs[`BBPS_R_RATIO][`BBPS_B_RATIO] ? {vt[14:0], 1'b0} : vt;

  // Loop settings are decoded from register bits but drive no output of this module.
  wire [5:0] peak_limit = regs[`BBPS_R_PEAK][5:0];
  wire [15:0] cc_level = {regs[`BBPS_R_CC_H], regs[`BBPS_R_CC_L]};
  wire adc_en = regs[`BBPS_R_CONV][`BBPS_B_ADC];
  wire [1:0] adc_avg = regs[`BBPS_R_CONV][7:6];
  wire adc_busc_en = regs[`BBPS_R_CONVX][`BBPS_B_ADC];

  bbps_seq_t st;
  logic [25:0] cnt;
  logic hw_dis;
  wire stop = !en_pin || !sw_en;
  wire switching = st == SEQ_RAMP || st == SEQ_PGDLY || st == SEQ_ON;
  wire pg_done = st == SEQ_PGDLY && !stop && cnt == 26'(PGON_CYC - 1);
  wire off_done = st == SEQ_PGOFF && cnt == 26'(PGOFF_CYC - 1);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= SEQ_OFF;
      cnt <= 26'h0;
      hw_dis <= 1'b0;
    end else if (!cmp.undervoltage_lockout_ok) begin
      st <= SEQ_OFF;
      cnt <= 26'h0;
      hw_dis <= 1'b0;
    end else begin
      cnt <= cnt + 26'h1;
      case (st)
        SEQ_OFF: begin
          cnt <= 26'h0;
          if (en_pin) st <= SEQ_WAIT;
        end
        SEQ_WAIT: if (!en_pin) st <= SEQ_OFF;
          else if (cnt == 26'(START_CYC - 1)) st <= SEQ_IDLE;
        SEQ_IDLE: if (!en_pin) st <= SEQ_OFF;
          else if (sw_en) st <= SEQ_SSCHG;
        SEQ_SSCHG, SEQ_RAMP, SEQ_PGDLY, SEQ_ON: begin
          if (stop) begin
            st <= SEQ_DIS;
            hw_dis <= !en_pin;
          end else if (st == SEQ_SSCHG && cmp.ss_above_0v7) begin
            st <= SEQ_RAMP;
          end else if (st == SEQ_RAMP && cmp.ss_end_2v3) begin
            st <= SEQ_PGDLY;
            cnt <= 26'h0;
          end else if (pg_done) begin
            st <= SEQ_ON;
          end
        end
        SEQ_DIS: begin
          cnt <= 26'h0;
          if (!en_pin) hw_dis <= 1'b1;
          if (!cmp.ss_above_0v7) st <= SEQ_PGOFF;
        end
        SEQ_PGOFF: if (off_done) begin
          st <= en_pin ? SEQ_IDLE : SEQ_OFF;
          hw_dis <= 1'b0;
        end
        default: st <= SEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      power_good_out <= 1'b0;
      ss_charge_en <= 1'b0;
      discharge_on <= 1'b0;
    end else begin
      if (!cmp.undervoltage_lockout_ok || off_done) power_good_out <= 1'b0;
      else if (pg_done) power_good_out <= 1'b1;
      ss_charge_en <= switching || st == SEQ_SSCHG;
      // Pin shutdown clears the control register, so the pin path forces the bleeder on.
      if (st == SEQ_DIS || st == SEQ_PGOFF) discharge_on <= hw_dis || !en_pin ||
        r_endis[`BBPS_B_DIS];
      else discharge_on <= 1'b0;
    end
  end

  // Switching oscillator and cycle-by-cycle switch control.
  logic [15:0] osc_cnt;
  logic sleep;
  wire osc_tick = osc_cnt == 16'(OSC_CYC - 1);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) osc_cnt <= 16'h0;
    else if (osc_tick || !switching) osc_cnt <= 16'h0;
    else osc_cnt <= osc_cnt + 16'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gates <= '0;
      sleep <= 1'b0;
      zcd_en <= 1'b0;
    end else if (!switching) begin
      gates <= '0;
      sleep <= 1'b0;
      zcd_en <= 1'b0;
    end else begin
      zcd_en <= !forced_continuous_mode;
      if (sleep && cmp.vout_below_ref) sleep <= 1'b0;
      if (osc_tick && !(sleep && !cmp.vout_below_ref)) begin
        gates <= GATE_ACT;
      end else if (gates == GATE_ACT && cmp.peak_trip) begin
        gates <= GATE_CMP;
      end else if (!forced_continuous_mode && gates == GATE_CMP && cmp.zero_current_detect) begin
        gates <= '0;
        sleep <= 1'b1;
      end
    end
  end

  // Voltage scaling walks one step per slew interval.
  logic [25:0] stc, to_cnt;
  logic moving_q, to_live, to_lat, pg_flag;
  wire [25:0] step_cyc = 26'(SLEW_CYC * int'(`BBPS_SLEW_MAX - {1'b0, slew}));
  wire moving = switching && dvs_level != tgt;
  wire reached = moving_q && !moving && switching;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dvs_level <= 16'h0;
      stc <= 26'h0;
      moving_q <= 1'b0;
    end else begin
      moving_q <= moving;
      if (!switching) begin
        dvs_level <= tgt;
        stc <= 26'h0;
      end else if (moving) begin
        stc <= stc + 26'h1;
        if (stc >= step_cyc - 26'h1) begin
          stc <= 26'h0;
          dvs_level <= (dvs_level < tgt) ? dvs_level + 16'h1 : dvs_level - 16'h1;
        end
      end
    end
  end

  wire clr_ok = wr_hit && !dig_rst;
  wire clr_pg = clr_ok && bus.ptr[5:0] == `BBPS_R_EVT && bus.wdata[`BBPS_B_PG];
  wire clr_to = clr_ok && bus.ptr[5:0] == `BBPS_R_TO_LAT && bus.wdata[`BBPS_B_TO];
  wire to_hit = moving && to_cnt == 26'(DVSTO_CYC - 1);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      to_cnt <= 26'h0;
      to_live <= 1'b0;
      to_lat <= 1'b0;
      pg_flag <= 1'b0;
    end else if (dig_rst) begin
      to_cnt <= 26'h0;
      to_live <= 1'b0;
      to_lat <= 1'b0;
      pg_flag <= 1'b0;
    end else begin
      to_cnt <= (moving && !to_hit) ? to_cnt + 26'h1 : 26'h0;
      if (to_hit) to_live <= 1'b1;
      else if (!moving) to_live <= 1'b0;
      // A new event wins over a clear in the same cycle.
      if (to_hit) to_lat <= 1'b1;
      else if (clr_to) to_lat <= 1'b0;
      if (reached || pg_done) pg_flag <= 1'b1;
      else if (clr_pg) pg_flag <= 1'b0;
    end
  end

  wire alert_cause = cmp.prot || !en_pin ||
    (pg_flag && !regs[`BBPS_R_EVTM][`BBPS_B_PG]) ||
    (to_lat && !regs[`BBPS_R_TOM][`BBPS_B_TO]);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) alert_n <= 1'b1;
    else alert_n <= !alert_cause;
  end

  logic [1:0] path_q;
  for (genvar i = 0; i < 2; i++) begin : g_path
    wire on = !dig_rst && r_path[i] && forward_mode && bus_is_5v &&
      !(cmp.prot && r_path[4 + i]);
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) path_q[i] <= 1'b0;
      else path_q[i] <= on ^ r_path[2 + i];
    end
  end
  assign typec_path_gate = path_q[0];
  assign typea_path_gate = path_q[1];

  wire [5:0] adc_idx = bus.ptr[5:0] - `BBPS_R_ADC0;
  always_comb begin
    rd_data = 8'h00;
    if (bus.ptr[7:6] == 2'b00) begin
      if (bus.ptr[5:0] == `BBPS_R_EVT) rd_data[`BBPS_B_PG] = pg_flag;
      else if (bus.ptr[5:0] == `BBPS_R_TO_LIVE) rd_data[`BBPS_B_TO] = to_live;
      else if (bus.ptr[5:0] == `BBPS_R_TO_LAT) rd_data[`BBPS_B_TO] = to_lat;
      else if (bus.ptr[5:0] >= `BBPS_R_ADC0 && adc_idx[5:1] < {2'b00, `BBPS_ADC_CH})
        rd_data = adc_idx[0] ? adc_result[adc_idx[3:1]][7:0]
          : {5'h00, adc_result[adc_idx[3:1]][10:8]};
      else if (is_rw(bus.ptr[5:0])) rd_data = regs[bus.ptr[5:0]];
    end
  end

  chk_undervoltage_lockout_gates: assert property (!cmp.undervoltage_lockout_ok |-> ##2 gates == '0 ##1 gates == '0)
    else $error("gates active under lockout");
  chk_pin_reset: assert property (!en_pin |=> !sw_en &&
    regs[`BBPS_R_CONV] == `BBPS_RST_CONV && regs[`BBPS_R_MODE] == `BBPS_RST_MODE)
    else $error("registers not reset by enable pin");
  chk_start_wait: assert property ($rose(st == SEQ_IDLE) && $past(st) == SEQ_WAIT
    |-> $past(cnt) == 26'(START_CYC - 1))
    else $error("start delay wrong");
  chk_no_early_ramp: assert property (st == SEQ_SSCHG && !cmp.ss_above_0v7
    |=> gates == '0 && st != SEQ_RAMP)
    else $error("switching before soft-start threshold");
  chk_pg_rise: assert property ($rose(power_good_out)
    |-> $past(st) == SEQ_PGDLY && $past(cnt) == 26'(PGON_CYC - 1))
    else $error("power good delay wrong");
  chk_pg_fall: assert property ($fell(power_good_out) && $past(cmp.undervoltage_lockout_ok)
    |-> $past(st) == SEQ_PGOFF && $past(cnt) == 26'(PGOFF_CYC - 1))
    else $error("power good fell at wrong time");
  chk_hw_bleed: assert property (st == SEQ_DIS && !en_pin |=> discharge_on)
    else $error("bleeder off on pin disable");
  chk_alert_flag: assert property ($rose(pg_flag) && !regs[`BBPS_R_EVTM][`BBPS_B_PG]
    |=> !alert_n)
    else $error("alert not pulled on target");
  chk_alert_mask: assert property (!alert_n && $past(en_pin) && !$past(cmp.prot)
    |-> $past(pg_flag && !regs[`BBPS_R_EVTM][`BBPS_B_PG] ||
    to_lat && !regs[`BBPS_R_TOM][`BBPS_B_TO]))
    else $error("alert low without unmasked cause");
  chk_peak_swap: assert property (gates == GATE_ACT && cmp.peak_trip && !osc_tick
    && switching |=> gates != GATE_ACT)
    else $error("peak trip ignored");
endmodule // bbps_core

//--- core/bbps_defs.svh
`ifndef BBPS_DEFS_SVH
`define BBPS_DEFS_SVH
`define BBPS_R_VTGT_L 6'h01
`define BBPS_R_VTGT_H 6'h02
`define BBPS_R_CC_L 6'h03
`define BBPS_R_CC_H 6'h04
`define BBPS_R_PEAK 6'h09
`define BBPS_R_MODE 6'h0D
`define BBPS_R_ENDIS 6'h0E
`define BBPS_R_CONV 6'h10
`define BBPS_R_RATIO 6'h11
`define BBPS_R_ADC0 6'h12
`define BBPS_R_EVT 6'h1F
`define BBPS_R_EVTM 6'h21
`define BBPS_R_PATH 6'h29
`define BBPS_R_CONVX 6'h32
`define BBPS_R_TO_LIVE 6'h37
`define BBPS_R_TO_LAT 6'h38
`define BBPS_R_TOM 6'h39
`define BBPS_ADC_CH 3'h5
`define BBPS_B_SWEN 7
`define BBPS_B_DIS 4
`define BBPS_B_FORCED_CONTINUOUS_MODE 7
`define BBPS_B_RATIO 5
`define BBPS_B_PG 6
`define BBPS_B_TO 2
`define BBPS_B_ADC 1
`define BBPS_SLEW_MAX 5'h10
`define BBPS_RST_ZERO 8'h00
`define BBPS_RST_MODE 8'h78
`define BBPS_RST_CONV 8'h82
`define BBPS_RST_CONVX 8'h00
`define BBPS_RST_PATH 8'hF0
`define BBPS_I2C_ADDR_HI 6'h16
`define BBPS_CLK_NS 8
`define BBPS_CLK_KHZ 125000
`define BBPS_NS_PER_MS 1000000
`define BBPS_T_START_NS 50000
`define BBPS_T_PGON_NS 512000
`define BBPS_T_PGOFF_NS 16000
`define BBPS_T_SLEW_NS 32000
`define BBPS_T_DVSTO_MS 275
`define BBPS_F_SW_KHZ 250
`endif

//--- core/bbps_pkg.sv
package bbps_pkg;
  typedef enum logic [3:0] {
    SEQ_OFF, SEQ_WAIT, SEQ_IDLE, SEQ_SSCHG, SEQ_RAMP, SEQ_PGDLY, SEQ_ON, SEQ_DIS, SEQ_PGOFF
  } bbps_seq_t;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WR, I2C_WACK, I2C_RD, I2C_RACK
  } bbps_i2c_st_t;
  typedef struct packed {
    logic buck_high;
    logic buck_low;
    logic boost_high;
    logic boost_low;
  } bbps_gate_t;
  typedef struct packed {
    logic wr;
    logic [7:0] ptr;
    logic [7:0] wdata;
  } bbps_regbus_t;
  typedef struct packed {
    logic undervoltage_lockout_ok;
    logic prot;
    logic ss_above_0v7;
    logic ss_end_2v3;
    logic zero_current_detect;
    logic peak_trip;
    logic vout_below_ref;
  } bbps_cmp_t;
endpackage

//--- core/bbps_i2c_target.sv
`include "bbps_defs.svh"
module bbps_i2c_target import bbps_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic srst,
  input wire logic [6:0] dev_addr,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic [7:0] rd_data,
  output logic sda_out,
  output logic sda_oe,
  output bbps_regbus_t bus
);
  logic scl_q, sda_q, rnw, have_ptr, wrote;
  logic [2:0] bitc;
  logic [7:0] sh;
  bbps_i2c_st_t st;
  wire start = scl && scl_q && sda_q && !sda_in;
  wire stop = scl && scl_q && !sda_q && sda_in;
  wire rise = scl && !scl_q;
  wire fall = !scl && scl_q;

  // The data line is open drain: only a low is ever driven.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= I2C_IDLE;
      bitc <= 3'h0;
      sh <= 8'h00;
      rnw <= 1'b0;
      have_ptr <= 1'b0;
      wrote <= 1'b0;
      sda_oe <= 1'b0;
      bus <= '0;
    end else begin
      bus.wr <= 1'b0;
      if (srst) begin
        st <= I2C_IDLE;
        sda_oe <= 1'b0;
        bus.ptr <= 8'h00;
      end else if (start) begin
        st <= I2C_ADDR;
        bitc <= 3'h0;
        have_ptr <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st <= I2C_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st)
          I2C_ADDR: if (rise) begin
            sh <= {sh[6:0], sda_in};
            bitc <= bitc + 3'h1;
            if (bitc == 3'h7) begin
              rnw <= sda_in;
              st <= (sh[6:0] == dev_addr) ? I2C_AACK : I2C_IDLE;
            end
          end
          I2C_AACK, I2C_WACK: if (fall) begin
            if (!sda_oe) begin
              sda_oe <= 1'b1;
            end else if (st == I2C_AACK && rnw) begin
              sh <= rd_data;
              sda_oe <= !rd_data[7];
              st <= I2C_RD;
              bitc <= 3'h0;
            end else begin
              sda_oe <= 1'b0;
              st <= I2C_WR;
              bitc <= 3'h0;
              wrote <= 1'b0;
              if (wrote) bus.ptr <= bus.ptr + 8'h01;
            end
          end
          I2C_WR: if (rise) begin
            sh <= {sh[6:0], sda_in};
            bitc <= bitc + 3'h1;
            if (bitc == 3'h7) begin
              st <= I2C_WACK;
              if (have_ptr) begin
                bus.wr <= 1'b1;
                bus.wdata <= {sh[6:0], sda_in};
                wrote <= 1'b1;
              end else begin
                bus.ptr <= {sh[6:0], sda_in};
                have_ptr <= 1'b1;
              end
            end
          end
          I2C_RD: if (fall) begin
            bitc <= bitc + 3'h1;
            if (bitc == 3'h7) begin
              sda_oe <= 1'b0;
              st <= I2C_RACK;
              bus.ptr <= bus.ptr + 8'h01;
            end else begin
              sda_oe <= !sh[6];
              sh <= {sh[6:0], 1'b0};
            end
          end
          I2C_RACK: begin
            if (rise && sda_in) begin
              st <= I2C_IDLE;
            end else if (fall) begin
              sh <= rd_data;
              sda_oe <= !rd_data[7];
              st <= I2C_RD;
              bitc <= 3'h0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  chk_addr_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(st == I2C_AACK) |-> $past(sh[6:0]) == dev_addr)
    else $error("acknowledged a foreign address");
endmodule // bbps_i2c_target

//--- verif/bbps_i2c_host.sv
module bbps_i2c_host (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 8;
  localparam logic [6:0] ADDR = 7'h2D;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Works as first and as repeated start, since SDA only falls while SCL is high.
  task automatic start();
    sda_low <= 1'b0;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda_low <= 1'b1;
    tick(H);
    scl <= 1'b0;
    tick(H);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda_low <= 1'b0;
    tick(H);
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_low <= !b;
    tick(H);
    scl <= 1'b1;
    tick(H);
    r = sda_line;
    scl <= 1'b0;
    tick(H);
  endtask
  // The ninth bit is always released, so a read of one byte ends with a NACK.
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      xbit(b[i], r[i]);
    end
    xbit(1'b1, a);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte({ADDR, 1'b0}, r);
    xbyte(p, r);
    xbyte(d, r);
    stop();
  endtask
  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte({ADDR, 1'b0}, r);
    xbyte(p, r);
    start();
    xbyte({ADDR, 1'b1}, r);
    xbyte(8'hFF, d);
    stop();
  endtask
endmodule // bbps_i2c_host

//--- verif/tb_top.sv
`include "bbps_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bbps_pkg::*;
  localparam int PGON = 40;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic en_pin = 1'b1;
  logic scl, sda_low, sda_oe, sda_line, pc, pa, dis_on, pg, alert_n, zero_current_detect, ssc;
  logic [15:0] dynamic_voltage_scaling;
  bbps_gate_t gates;
  bbps_cmp_t cmp = 7'h40;
  logic [4:0][10:0] adc = '0;
  logic [7:0] mdl [64];
  logic [7:0] rd;
  logic [31:0] seed = 32'hF678AF0D;
  logic [7:0] ro [6] = '{8'h0D, 8'h10, 8'h32, 8'h29, 8'h12, 8'h13};
  logic [7:0] wo [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h09, 8'h11, 8'h05};
  int err_total = 0;
  int check_count = 0;
  int n;
  assign sda_line = !(sda_oe | sda_low);
  always #4 clk_sys = ~clk_sys;
  bbps_core #(.START_CYC(20), .PGON_CYC(PGON), .DVSTO_CYC(200)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .en_pin(en_pin), .addr_sel(1'b1), .scl(scl),
    .sda_in(sda_line), .forward_mode(1'b1), .bus_is_5v(1'b1), .cmp_raw(cmp),
    .adc_result(adc), .sda_out(), .sda_oe(sda_oe), .gates(gates), .typec_path_gate(pc),
    .typea_path_gate(pa), .ss_charge_en(ssc), .discharge_on(dis_on), .power_good_out(pg),
    .alert_n(alert_n), .zcd_en(zero_current_detect), .dvs_level(dynamic_voltage_scaling));
  bbps_i2c_host i_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic mdl_init();
    for (int i = 0; i < 64; i++) mdl[i] = 8'h00;
    mdl[`BBPS_R_MODE] = `BBPS_RST_MODE;
    mdl[`BBPS_R_CONV] = `BBPS_RST_CONV;
    mdl[`BBPS_R_CONVX] = `BBPS_RST_CONVX;
    mdl[`BBPS_R_PATH] = `BBPS_RST_PATH;
    mdl[8'h12] = {5'h00, adc[0][10:8]};
    mdl[8'h13] = adc[0][7:0];
  endtask
  task automatic rd_chk(input logic [7:0] o);
    i_host.rd_reg(o, rd);
    chk(rd, mdl[o[5:0]]);
  endtask
  // Offset 0x05 is unmapped, so the model keeps it at zero.
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    i_host.wr_reg(o, d);
    if (o != 8'h05) mdl[o[5:0]] = d;
  endtask
  // Software enable, then let the soft-start node pass its threshold and wait for switching.
  task automatic run_up();
    wr(`BBPS_R_ENDIS, 8'h80);
    cmp.ss_above_0v7 <= 1'b1;
    n = 0;
    while (gates === 4'h0 && n < 1200) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic wait_pg(input logic v, input int lim);
    n = 0;
    while (pg !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    adc[0] = seed[10:0];
    mdl_init();
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk_sys);
    foreach (ro[i]) rd_chk(ro[i]);
    foreach (wo[i]) begin
      seed = lfsr(seed);
      wr(wo[i], seed[7:0]);
      rd_chk(wo[i]);
    end
    chk(dynamic_voltage_scaling, {mdl[2], mdl[1]} << mdl[8'h11][5]);
    $display("registers done");
    wr(`BBPS_R_PATH, 8'hF3);
    run_up();
    chk(gates, 4'b1001);
    chk({pc, pa, zero_current_detect, ssc}, 4'hF);
    cmp.peak_trip <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(gates, 4'b0110);
    cmp.peak_trip <= 1'b0;
    cmp.zero_current_detect <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(gates, 4'b0000);
    cmp.zero_current_detect <= 1'b0;
    cmp.ss_end_2v3 <= 1'b1;
    wait_pg(1'b1, 200);
    chk(n >= PGON && n <= PGON + 6, 1'b1);
    repeat (2) @(posedge clk_sys);
    chk(alert_n, 1'b0);
    wr(`BBPS_R_EVTM, 8'h40);
    chk(alert_n, 1'b1);
    i_host.rd_reg(`BBPS_R_EVT, rd);
    chk(rd[6], 1'b1);
    // Each scaling step takes far longer than the shortened timeout, so the timeout must fire.
    wr(`BBPS_R_VTGT_L, mdl[1] + 8'h01);
    i_host.rd_reg(`BBPS_R_TO_LAT, rd);
    chk({rd[2], alert_n}, 2'b10);
    $display("start-up done");
    wr(`BBPS_R_ENDIS, 8'h10);
    chk(dis_on, 1'b1);
    cmp.ss_above_0v7 <= 1'b0;
    cmp.ss_end_2v3 <= 1'b0;
    wait_pg(1'b0, 2200);
    chk(n >= 2000 && n <= 2006, 1'b1);
    cmp.prot <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({pc, pa, alert_n}, 3'b000);
    cmp.prot <= 1'b0;
    run_up();
    en_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({dis_on, alert_n, gates}, 6'b100000);
    en_pin <= 1'b1;
    cmp.ss_above_0v7 <= 1'b0;
    repeat (30) @(posedge clk_sys);
    mdl_init();
    rd_chk(`BBPS_R_PATH);
    $display("shutdown done");
    wr(`BBPS_R_VTGT_L, 8'h5A);
    rd_chk(`BBPS_R_VTGT_L);
    wr(`BBPS_R_MODE, 8'hF8);
    run_up();
    chk(zero_current_detect, 1'b0);
    cmp.undervoltage_lockout_ok <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({gates, pg}, 5'b00000);
    cmp.undervoltage_lockout_ok <= 1'b1;
    repeat (30) @(posedge clk_sys);
    mdl_init();
    rd_chk(`BBPS_R_VTGT_L);
    rd_chk(`BBPS_R_MODE);
    $display("lockout done");
    final_report();
  end
  // Sized at about twice the expected run so a stuck bus cannot hang the run.
  initial begin
    repeat (70000) @(posedge clk_sys);
    err_total++;
    final_report();
  end
endmodule // tb_top
